// file: logic/usb_port_pkg.sv
// shared constants and types for the root port status and control block
package usb_port_pkg;
  localparam logic [7:0] PORT_SC_ADDR   = 8'h54;
  localparam logic [7:0] CTRL_STAT_ADDR = 8'h04;
  localparam int         CCS_BIT = 0;
  localparam int         CSC_BIT = 1;
  localparam int         PE_BIT  = 2;
  localparam int         PEC_BIT = 3;
  localparam int         OCA_BIT = 4;
  localparam int         OCC_BIT = 5;
  localparam int         FPR_BIT = 6;
  localparam int         SUS_BIT = 7;
  localparam int         PR_BIT  = 8;
  localparam int         PCD_BIT = 2;
  localparam int         CLK_HZ    = 40_000_000;
  localparam int         SETTLE_MS = 2;
  // longest settle time, rounded down to whole cycles
  localparam int         SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;

  typedef enum logic [1:0] {PS_DISABLED, PS_ENABLED, PS_SUSPENDED} port_state_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_RESET_EXIT, SQ_RESUME_EXIT} seq_t;

  typedef struct packed {
    logic connect;
    logic over_current;
    logic k_state;
  } line_in_t;

  typedef struct packed {
    logic pr;
    logic sus;
    logic fpr;
    logic occ;
    logic oca;
    logic pec;
    logic pe;
    logic csc;
    logic ccs;
  } port_sc_t;

  localparam port_sc_t PORT_SC_RESET = 9'h000;
endpackage

// file: logic/port_status_ctrl.sv
// root port status and control register with suspend, resume, enable and change flags
//
// Overview of operation
// - suspend writes of zero ignored; cleared on resume end or reset start
// - suspend reads set only once the port truly entered suspend
// - port power off holds suspend, resume, enable and connect fields at zero
// - J-to-K while suspended sets force-resume and port change detect
// - software setting force-resume leaves port change detect alone
// - drive K while force-resume; after clear, return to idle within 2 ms
// - over-current change set on every toggle, cleared by writing one
// - over-current active follows the live over-current condition
// - enable change set only on port error disable at end of frame
// - enable set only by reset sequence with high-speed device
// - enable cleared on disconnect, fault or software, once state changes
// - disabled port blocks downstream data except reset signalling
// - connect change set on every connect status change, cleared by one
// - connect status shows whether a device is attached now
// - register reset only by hardware or host controller reset
// - port state decoded from enable and suspend: 0x, 10, 11
// - suspend blocks downstream data from transaction end, stays resume aware
// - after reset clear, settle within 2 ms and enable if high-speed
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module port_status_ctrl #(
  parameter int SETTLE_CYC = usb_port_pkg::SETTLE_CYC
) (
  input  wire logic                   clk_sys,         // 40 MHz system clock
  input  wire logic                   rst_n,           // async hardware reset
  input  wire logic                   hc_reset,        // host controller reset
  input  wire logic                   port_power,      // port power on
  input  wire usb_port_pkg::line_in_t line_in,         // raw line side levels
  input  wire logic                   txn_busy,        // transaction in progress
  input  wire logic                   eof2_error,      // port error at frame end
  input  wire logic                   fault,           // other port fault
  input  wire logic                   hs_device,       // high-speed device seen
  input  wire logic [7:0]             addr,            // register byte address
  input  wire logic [31:0]            wdata,           // write data
  input  wire logic                   wr_en,           // write strobe
  input  wire logic                   rd_en,           // read strobe
  output logic [31:0]                 rdata_q,         // read data
  output logic                        drive_k_q,       // drive resume K
  output logic                        bus_reset_q,     // drive bus reset
  output logic                        downstream_en_q, // downstream data allowed
  output usb_port_pkg::port_state_t   port_state_q     // decoded port state
);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  usb_port_pkg::line_in_t    line_meta_q;
  usb_port_pkg::line_in_t    line_q;
  logic                      k_prev_q;
  usb_port_pkg::port_sc_t    sc_q;
  usb_port_pkg::port_sc_t    sc_d;
  logic                      pcd_q;
  logic                      pcd_d;
  logic                      sus_pend_q;
  logic                      sus_pend_d;
  usb_port_pkg::seq_t        seq_q;
  usb_port_pkg::seq_t        seq_d;
  logic [CW-1:0]             cnt_q;
  logic [CW-1:0]             cnt_d;
  logic [31:0]               rdata_d;
  logic                      drive_k_d;
  logic                      bus_reset_d;
  logic                      downstream_en_d;
  usb_port_pkg::port_state_t port_state_d;
  logic                      wr_sc;
  logic                      wr_st;
  logic                      j_to_k;
  logic                      cnt_done;

  // line pins pass two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_meta_q <= 3'h0;
      line_q      <= 3'h0;
      k_prev_q    <= 1'b0;
    end else begin
      line_meta_q <= line_in;
      line_q      <= line_meta_q;
      k_prev_q    <= line_q.k_state;
    end
  end

  assign wr_sc    = wr_en && (addr == usb_port_pkg::PORT_SC_ADDR);
  assign wr_st    = wr_en && (addr == usb_port_pkg::CTRL_STAT_ADDR);
  assign j_to_k   = line_q.k_state && !k_prev_q;
  assign cnt_done = (cnt_q == CW'(SETTLE_CYC - 1));

  always_comb begin
    sc_d       = sc_q;
    pcd_d      = pcd_q;
    sus_pend_d = sus_pend_q;
    seq_d      = seq_q;
    cnt_d      = cnt_q;
    sc_d.ccs = line_q.connect;
    // set on every change, set wins over clear
    if (line_q.connect != sc_q.ccs) begin
      sc_d.csc = 1'b1;
    end else if (wr_sc && wdata[usb_port_pkg::CSC_BIT]) begin
      sc_d.csc = 1'b0;
    end
    sc_d.oca = line_q.over_current;
    if (line_q.over_current != sc_q.oca) begin
      sc_d.occ = 1'b1;
    end else if (wr_sc && wdata[usb_port_pkg::OCC_BIT]) begin
      sc_d.occ = 1'b0;
    end
    // end of frame port error disables and flags
    if (sc_q.pe && eof2_error) begin
      sc_d.pe  = 1'b0;
      sc_d.pec = 1'b1;
    end else if (wr_sc && wdata[usb_port_pkg::PEC_BIT]) begin
      sc_d.pec = 1'b0;
    end
    // disconnect, fault or software write of zero disables
    if (fault || (sc_q.ccs && !line_q.connect) || (wr_sc && !wdata[usb_port_pkg::PE_BIT])) begin
      sc_d.pe = 1'b0;
    end
    if (wr_st && wdata[usb_port_pkg::PCD_BIT]) begin
      pcd_d = 1'b0;
    end
    // suspend request waits for the bus to go quiet
    if (wr_sc && wdata[usb_port_pkg::SUS_BIT] && !sc_q.sus && sc_q.pe) begin
      sus_pend_d = 1'b1;
    end
    if (sus_pend_q && !txn_busy) begin
      sc_d.sus   = sus_pend_q;
      sus_pend_d = 1'b0;
    end
    // software resume does not touch change detect
    if (wr_sc && wdata[usb_port_pkg::FPR_BIT] && !sc_q.fpr) begin
      sc_d.fpr = 1'b1;
    end
    // remote wake K sets resume and change detect
    if (sc_q.sus && j_to_k) begin
      sc_d.fpr = 1'b1;
      pcd_d    = 1'b1;
    end
    case (seq_q)
      usb_port_pkg::SQ_IDLE: begin
        cnt_d = '0;
        if (wr_sc && !wdata[usb_port_pkg::FPR_BIT] && sc_q.fpr) begin
          seq_d = usb_port_pkg::SQ_RESUME_EXIT;
        end
        if (wr_sc && !wdata[usb_port_pkg::PR_BIT] && sc_q.pr) begin
          seq_d = usb_port_pkg::SQ_RESET_EXIT;
        end
      end
      usb_port_pkg::SQ_RESUME_EXIT: begin
        cnt_d = cnt_q + 1'b1;
        // bit stays one until back at high-speed idle
        if (cnt_done) begin
          sc_d.fpr = 1'b0;
          sc_d.sus = 1'b0;
          seq_d    = usb_port_pkg::SQ_IDLE;
        end
      end
      usb_port_pkg::SQ_RESET_EXIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_done) begin
          sc_d.pr = 1'b0;
          sc_d.pe = hs_device && sc_q.ccs;
          seq_d   = usb_port_pkg::SQ_IDLE;
        end
      end
      default: begin
        seq_d = usb_port_pkg::SQ_IDLE;
        cnt_d = '0;
      end
    endcase
    if (wr_sc && wdata[usb_port_pkg::PR_BIT] && !sc_q.pr) begin
      sc_d.pr    = 1'b1;
      sc_d.sus   = 1'b0;
      sc_d.pe    = 1'b0;
      sus_pend_d = 1'b0;
      seq_d      = usb_port_pkg::SQ_IDLE;
      cnt_d      = '0;
    end
    // power off forces fields to zero
    if (!port_power) begin
      sc_d.sus   = 1'b0;
      sc_d.fpr   = 1'b0;
      sc_d.pe    = 1'b0;
      sc_d.pec   = 1'b0;
      sc_d.csc   = 1'b0;
      sc_d.ccs   = 1'b0;
      sc_d.pr    = 1'b0;
      sus_pend_d = 1'b0;
      seq_d      = usb_port_pkg::SQ_IDLE;
      cnt_d      = '0;
    end
    if (hc_reset) begin
      sc_d       = usb_port_pkg::PORT_SC_RESET;
      pcd_d      = 1'b0;
      sus_pend_d = 1'b0;
      seq_d      = usb_port_pkg::SQ_IDLE;
      cnt_d      = '0;
    end
  end

  always_comb begin
    // state decode from enable and suspend
    if (!sc_d.pe) begin
      port_state_d = usb_port_pkg::PS_DISABLED;
    end else if (sc_d.sus) begin
      port_state_d = usb_port_pkg::PS_SUSPENDED;
    end else begin
      port_state_d = usb_port_pkg::PS_ENABLED;
    end
    // resume K only until the exit starts
    drive_k_d       = sc_d.fpr && (seq_d != usb_port_pkg::SQ_RESUME_EXIT);
    bus_reset_d     = sc_d.pr;
    // disabled or suspended port passes no data
    downstream_en_d = sc_d.pe && !sc_d.sus && !sc_d.pr;
    rdata_d         = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        usb_port_pkg::PORT_SC_ADDR: begin
          rdata_d = {23'h000000, sc_q};
        end
        usb_port_pkg::CTRL_STAT_ADDR: begin
          rdata_d[usb_port_pkg::PCD_BIT] = pcd_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sc_q            <= usb_port_pkg::PORT_SC_RESET;
      pcd_q           <= 1'b0;
      sus_pend_q      <= 1'b0;
      seq_q           <= usb_port_pkg::SQ_IDLE;
      cnt_q           <= '0;
      rdata_q         <= 32'h0000_0000;
      drive_k_q       <= 1'b0;
      bus_reset_q     <= 1'b0;
      downstream_en_q <= 1'b0;
      port_state_q    <= usb_port_pkg::PS_DISABLED;
    end else begin
      sc_q            <= sc_d;
      pcd_q           <= pcd_d;
      sus_pend_q      <= sus_pend_d;
      seq_q           <= seq_d;
      cnt_q           <= cnt_d;
      rdata_q         <= rdata_d;
      drive_k_q       <= drive_k_d;
      bus_reset_q     <= bus_reset_d;
      downstream_en_q <= downstream_en_d;
      port_state_q    <= port_state_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_sus_waits_idle: assert property ($rose(sc_q.sus) |-> $past(!txn_busy))
    else $error("suspend set during a transaction");
  a_power_off_zero: assert property (!port_power |=> {sc_q.sus, sc_q.fpr, sc_q.pe, sc_q.pec,
    sc_q.csc, sc_q.ccs} == 6'h00)
    else $error("fields not zero with power off");
  a_jk_sets_resume: assert property (sc_q.sus && j_to_k && port_power && !hc_reset
    |=> sc_q.fpr && pcd_q)
    else $error("J-to-K in suspend missed");
  a_sw_resume_pcd: assert property (!pcd_q && !(sc_q.sus && j_to_k) |=> !pcd_q)
    else $error("change detect set without line resume");
  a_resume_exit_len: assert property ($fell(sc_q.fpr) && $past(port_power) && !$past(hc_reset)
    |-> $past(seq_q == usb_port_pkg::SQ_RESUME_EXIT) && $past(cnt_done))
    else $error("force resume cleared before exit finished");
  a_oc_change_set: assert property (port_power && !hc_reset
    && (line_q.over_current != sc_q.oca) |=> sc_q.occ)
    else $error("over-current toggle not flagged");
  a_pec_cause: assert property ($rose(sc_q.pec) |-> $past(eof2_error && sc_q.pe))
    else $error("enable change without port error");
  a_sw_no_enable: assert property (wr_sc && wdata[usb_port_pkg::PE_BIT] && !sc_q.pe
    && seq_q != usb_port_pkg::SQ_RESET_EXIT |=> !sc_q.pe)
    else $error("software enabled the port");
  a_block_data: assert property (!sc_q.pe |-> !downstream_en_q)
    else $error("data allowed on disabled port");
  a_csc_set: assert property (port_power && !hc_reset
    && (line_q.connect != sc_q.ccs) |=> sc_q.csc)
    else $error("connect change not flagged");
  a_state_decode: assert property (port_state_q == (!sc_q.pe ? usb_port_pkg::PS_DISABLED :
    sc_q.sus ? usb_port_pkg::PS_SUSPENDED : usb_port_pkg::PS_ENABLED))
    else $error("port state decode wrong");
  a_w1c_zero_keeps: assert property (wr_sc && !wdata[usb_port_pkg::CSC_BIT] && sc_q.csc
    && port_power && !hc_reset |=> sc_q.csc)
    else $error("zero write cleared connect change");
endmodule // port_status_ctrl

// file: tb/usb_dev_model.sv
// attached high-speed usb device model on the far side of the root port
`timescale 1ns/1ps
module usb_dev_model (
  input  wire logic              clk_sys,     // system clock
  input  wire logic              bus_reset_q, // host drives bus reset
  output usb_port_pkg::line_in_t line_in,     // connect, over-current, k
  output logic                   hs_device    // chirp seen during reset
);
  logic attached = 1'b0;
  logic oc       = 1'b0;
  logic k_drv    = 1'b0;
  // a detached port shows no connect and no k
  assign line_in = '{connect: attached, over_current: oc, k_state: attached & k_drv};
  always_ff @(posedge clk_sys)
    hs_device <= attached & (hs_device | bus_reset_q);
  task automatic attach(input logic v);
    attached <= v;
  endtask
  task automatic over(input logic v);
    oc <= v;
  endtask
  task automatic resume_k();
    k_drv <= 1'b1;
    repeat (4) @(posedge clk_sys);
    k_drv <= 1'b0;
  endtask
endmodule // usb_dev_model

// file: tb/test_usb_host_port_status_control.sv
// self-checking bench for the root port status and control block
`timescale 1ns/1ps
module test_usb_host_port_status_control;
  localparam int SETTLE = 8;
  localparam logic [31:0] B_CCS = 32'h1 << usb_port_pkg::CCS_BIT;
  localparam logic [31:0] B_CSC = 32'h1 << usb_port_pkg::CSC_BIT;
  localparam logic [31:0] B_PE  = 32'h1 << usb_port_pkg::PE_BIT;
  localparam logic [31:0] B_PEC = 32'h1 << usb_port_pkg::PEC_BIT;
  localparam logic [31:0] B_OCA = 32'h1 << usb_port_pkg::OCA_BIT;
  localparam logic [31:0] B_OCC = 32'h1 << usb_port_pkg::OCC_BIT;
  localparam logic [31:0] B_FPR = 32'h1 << usb_port_pkg::FPR_BIT;
  localparam logic [31:0] B_SUS = 32'h1 << usb_port_pkg::SUS_BIT;
  localparam logic [31:0] B_PR  = 32'h1 << usb_port_pkg::PR_BIT;
  localparam logic [31:0] B_PCD = 32'h1 << usb_port_pkg::PCD_BIT;
  logic clk_sys, rst_n, hc_reset, port_power, txn_busy, eof2_error, fault, wr_en, rd_en;
  logic drive_k_q, bus_reset_q, downstream_en_q, hs_device;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata_q, rv, m, rng;
  usb_port_pkg::line_in_t    line_in;
  usb_port_pkg::port_state_t port_state_q;
  int n_errors, cmp_count;
  usb_dev_model i_dev (.clk_sys(clk_sys), .bus_reset_q(bus_reset_q), .line_in(line_in),
    .hs_device(hs_device));
  port_status_ctrl #(.SETTLE_CYC(SETTLE)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .hc_reset(hc_reset), .port_power(port_power), .line_in(line_in), .txn_busy(txn_busy),
    .eof2_error(eof2_error), .fault(fault), .hs_device(hs_device), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .drive_k_q(drive_k_q),
    .bus_reset_q(bus_reset_q), .downstream_en_q(downstream_en_q), .port_state_q(port_state_q));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // random noise on fault, frame error and busy; only while the port is disabled
  task automatic idle(input int n);
    repeat (n) begin
      rng = xs(rng);
      {fault, eof2_error, txn_busy} <= rng[2:0];
      @(posedge clk_sys);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // unimplemented upper bits get random data and must read back zero
  task automatic wrp(input logic [31:0] d);
    rng = xs(rng);
    wr(usb_port_pkg::PORT_SC_ADDR, d | (rng & 32'hfffffe00));
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    rv = rdata_q;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_sc(input string what);
    rd(usb_port_pkg::PORT_SC_ADDR);
    chk(what, m, rv);
  endtask
  task automatic port_reset();
    wrp(B_PR);
    m = (m | B_PR) & ~(B_PE | B_SUS);
    chk_sc("reset start");
    chk("bus reset", 32'h1, {31'h0, bus_reset_q});
    wrp(32'h0);
    chk_sc("reset held");
    cyc(SETTLE + 4);
    m = (m & ~B_PR) | B_PE;
    chk_sc("reset end");
    chk("state en", {30'h0, usb_port_pkg::PS_ENABLED}, {30'h0, port_state_q});
    chk("ds on", 32'h1, {31'h0, downstream_en_q});
    chk("bus reset off", 32'h0, {31'h0, bus_reset_q});
  endtask
  task automatic resume_exit();
    wrp(B_PE);
    chk_sc("fpr held");
    cyc(SETTLE + 4);
    m = m & ~(B_FPR | B_SUS);
    chk_sc("resume end");
    chk("k off", 32'h0, {31'h0, drive_k_q});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(3000);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    rst_n      = 1'b0;
    hc_reset   = 1'b0;
    port_power = 1'b1;
    txn_busy   = 1'b0;
    eof2_error = 1'b0;
    fault      = 1'b0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    rng        = 32'h805ea742;
    m          = 32'h0;
    cyc(10);
    rst_n <= 1'b1;
    chk_sc("after reset");
    rng = xs(rng);
    wr({1'b1, rng[6:0]}, 32'hffffffff);
    rd({1'b1, rng[6:0]});
    chk("unmapped", 32'h0, rv);
    i_dev.attach(1'b1);
    idle(6);
    m = m | B_CCS | B_CSC;
    chk_sc("connect");
    wrp(32'h0);
    chk_sc("zero write");
    i_dev.attach(1'b0);
    idle(6);
    i_dev.attach(1'b1);
    idle(6);
    chk_sc("double change");
    wrp(B_CSC);
    m = m & ~B_CSC;
    chk_sc("csc clear");
    i_dev.over(1'b1);
    idle(6);
    m = m | B_OCA | B_OCC;
    chk_sc("oc on");
    i_dev.over(1'b0);
    idle(6);
    m = m & ~B_OCA;
    chk_sc("oc off");
    wrp(B_OCC);
    m = m & ~B_OCC;
    chk_sc("occ clear");
    wrp(B_PE);
    chk_sc("pe by write");
    $display("test flags done");
    {fault, eof2_error, txn_busy} <= 3'h0;
    port_reset();
    txn_busy <= 1'b1;
    wrp(B_PE | B_SUS);
    cyc(3);
    chk_sc("suspend waits");
    txn_busy <= 1'b0;
    cyc(3);
    m = m | B_SUS;
    chk_sc("suspended");
    chk("state sus", {30'h0, usb_port_pkg::PS_SUSPENDED}, {30'h0, port_state_q});
    chk("ds blocked", 32'h0, {31'h0, downstream_en_q});
    wrp(B_PE);
    chk_sc("sus zero write");
    wr(usb_port_pkg::CTRL_STAT_ADDR, B_PCD);
    i_dev.resume_k();
    cyc(4);
    m = m | B_FPR;
    chk_sc("k resume");
    rd(usb_port_pkg::CTRL_STAT_ADDR);
    chk("pcd", B_PCD, rv);
    chk("drive k", 32'h1, {31'h0, drive_k_q});
    resume_exit();
    wr(usb_port_pkg::CTRL_STAT_ADDR, B_PCD);
    wrp(B_PE | B_SUS);
    cyc(2);
    wrp(B_PE | B_SUS | B_FPR);
    m = m | B_SUS | B_FPR;
    chk_sc("sw resume");
    rd(usb_port_pkg::CTRL_STAT_ADDR);
    chk("pcd kept", 32'h0, rv);
    chk("drive k sw", 32'h1, {31'h0, drive_k_q});
    resume_exit();
    $display("test suspend done");
    eof2_error <= 1'b1;
    cyc(1);
    eof2_error <= 1'b0;
    cyc(3);
    m = (m & ~B_PE) | B_PEC;
    chk_sc("eof2 disable");
    chk("ds off", 32'h0, {31'h0, downstream_en_q});
    wrp(B_PEC);
    m = m & ~B_PEC;
    chk_sc("pec clear");
    port_reset();
    wrp(32'h0);
    m = m & ~B_PE;
    chk_sc("sw disable");
    chk("state dis", {30'h0, usb_port_pkg::PS_DISABLED}, {30'h0, port_state_q});
    port_reset();
    fault <= 1'b1;
    cyc(1);
    fault <= 1'b0;
    cyc(3);
    m = m & ~B_PE;
    chk_sc("fault disable");
    port_reset();
    i_dev.attach(1'b0);
    cyc(6);
    m = (m & ~(B_CCS | B_PE)) | B_CSC;
    chk_sc("detach");
    chk("ds detach", 32'h0, {31'h0, downstream_en_q});
    wrp(B_PR);
    m = m | B_PR;
    wrp(32'h0);
    cyc(SETTLE + 4);
    m = m & ~B_PR;
    chk_sc("reset no device");
    hc_reset <= 1'b1;
    cyc(1);
    hc_reset <= 1'b0;
    m = 32'h0;
    chk_sc("hc reset");
    i_dev.attach(1'b1);
    cyc(6);
    port_power <= 1'b0;
    cyc(3);
    chk_sc("power off");
    $display("test disable done");
    end_of_test();
  end
endmodule // test_usb_host_port_status_control
